// ==== rtl/dss_params.svh ====
// constants of the dual-slope sequencer and output control
// Operation
// - 12-bit result counter latched with sign and over-range, three-state drivers
// - full-scale result is 4096 counts, at input equal to twice reference
// - output-mode low or open keeps direct mode, read by chip and byte selects
// - a high pulse on output-mode sends two bytes by handshake, then direct
// - output-mode held high sends by handshake after every conversion
// - status rises at the start of signal integrate
// - status falls half a clock after latching; latches never change while low
// - gate high runs conversions continuously, 8192 clocks each
// - output latches load at zero crossing during reference phase
// - gate low after zero crossing ends reference phase, jumps to auto-zero
// - gate low: finish minimum auto-zero, then stay until gate high
// - gate low during auto-zero halts at its end until gate high
// - integrate and status rise seven clocks after gate sampled high
// - low byte holds bits 1-8; high byte bits 9-12, sign, over-range
// - chip-select and byte-selects are active-low inputs, pulled up
// - byte drivers enabled in direct mode with chip-select and that byte select low; in handshake by the sequencer
// - each cycle runs auto-zero, integrate, then reference phase
// - integrate lasts 2048 clocks; polarity taken at its end
// - reference phase counts clocks to zero crossing as the magnitude
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

`define DSS_CLK_NS     25
`define DSS_AZ_LEN     13'h0800
`define DSS_INT_LEN    13'h0800
`define DSS_DE_LEN     13'h1000
`define DSS_CYCLE_LEN  14'h2000
`define DSS_START_DLY  13'h0007
`define DSS_RES_W      12
`define DSS_LO_MSB     7
`define DSS_HI_LSB     8
`define DSS_RESULT_RST 12'h000

`endif

// ==== rtl/dss_pkg.sv ====
// types of the dual-slope sequencer and output control
package dss_pkg;
    typedef enum logic [4:0] {
        PH_AZ    = 5'h01,
        PH_WAIT  = 5'h02,
        PH_START = 5'h04,
        PH_INT   = 5'h08,
        PH_DE    = 5'h10
    } dss_phase_t;

    typedef enum logic [5:0] {
        HS_IDLE   = 6'h01,
        HS_WAIT_H = 6'h02,
        HS_LOAD_H = 6'h04,
        HS_HOLD_H = 6'h08,
        HS_LOAD_L = 6'h10,
        HS_HOLD_L = 6'h20
    } dss_hs_t;

    typedef logic [12:0] dss_cnt_t;
endpackage : dss_pkg

// ==== rtl/dss_hs_if.sv ====
// signals between the sequencer core and the handshake output sequencer
`timescale 1ns/1ps
interface dss_hs_if;
    logic start;
    logic send;
    logic busy;
    logic load_n;
    logic hi_n;
    logic lo_n;
    logic drv_hi;
    logic drv_lo;

    modport ctrl (output start, output send, input busy, input load_n,
                  input hi_n, input lo_n, input drv_hi, input drv_lo);
    modport seq  (input start, input send, output busy, output load_n,
                  output hi_n, output lo_n, output drv_hi, output drv_lo);
endinterface : dss_hs_if

// ==== rtl/dss_hs_seq.sv ====
// two-byte handshake output sequencer, high byte first
`timescale 1ns/1ps
module dss_hs_seq (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    dss_hs_if.seq     hs
);
    dss_pkg::dss_hs_t st_reg;
    dss_pkg::dss_hs_t st_next;

    // each byte waits for the receiver to be ready before its load strobe
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            dss_pkg::HS_IDLE:   if (hs.start) st_next = dss_pkg::HS_WAIT_H;
            dss_pkg::HS_WAIT_H: if (hs.send) st_next = dss_pkg::HS_LOAD_H;
            dss_pkg::HS_LOAD_H: st_next = dss_pkg::HS_HOLD_H;
            dss_pkg::HS_HOLD_H: if (hs.send) st_next = dss_pkg::HS_LOAD_L;
            dss_pkg::HS_LOAD_L: st_next = dss_pkg::HS_HOLD_L;
            dss_pkg::HS_HOLD_L: if (hs.send) st_next = dss_pkg::HS_IDLE;
            default:            st_next = dss_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= dss_pkg::HS_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hs.busy   = (st_reg != dss_pkg::HS_IDLE);
    assign hs.load_n = !(st_reg == dss_pkg::HS_LOAD_H || st_reg == dss_pkg::HS_LOAD_L);
    assign hs.drv_hi = (st_reg == dss_pkg::HS_LOAD_H || st_reg == dss_pkg::HS_HOLD_H);
    assign hs.drv_lo = (st_reg == dss_pkg::HS_LOAD_L || st_reg == dss_pkg::HS_HOLD_L);
    assign hs.hi_n   = !hs.drv_hi;
    assign hs.lo_n   = !hs.drv_lo;
endmodule : dss_hs_seq

// ==== rtl/dss_ctrl.sv ====
// dual-slope converter phase sequencer, result latches and output control
`timescale 1ns/1ps
`include "dss_params.svh"
module dss_ctrl (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       run_hold,
    input  wire logic       mode_in,
    input  wire logic       send,
    input  wire logic       cmp_zero,
    input  wire logic       cmp_pos,
    input  wire logic       chip_sel_n_in,
    output logic            chip_sel_n_out,
    output logic            chip_sel_n_oe,
    input  wire logic       high_byte_select_n_in,
    output logic            high_byte_select_n_out,
    output logic            high_byte_select_n_oe,
    input  wire logic       low_byte_select_n_in,
    output logic            low_byte_select_n_out,
    output logic            low_byte_select_n_oe,
    output logic [7:0]      lo_byte_out,
    output logic            lo_byte_oe,
    output logic [5:0]      hi_byte_out,
    output logic            hi_byte_oe,
    output logic            status,
    output logic            zero_phase,
    output logic            int_phase,
    output logic            reference_phase,
    output logic            sign_bit
);
    // =====================================================================
    // state and storage
    dss_pkg::dss_phase_t        ph_reg;
    dss_pkg::dss_phase_t        ph_next;
    dss_pkg::dss_cnt_t          cnt_reg;
    dss_pkg::dss_cnt_t          cnt_next;
    logic                       crossed_reg;
    logic                       sign_reg;
    logic [`DSS_RES_W-1:0]      result_reg;
    logic                       res_sign_reg;
    logic                       over_reg;
    logic                       latch_done_reg;
    logic                       status_reg;
    logic                       zph_reg;
    logic                       mode_prev_reg;
    logic                       hs_req_reg;
    logic                       chip_sel_n_out_reg;
    logic                       chip_sel_n_oe_reg;
    logic                       hb_out_reg;
    logic                       hb_oe_reg;
    logic                       lb_out_reg;
    logic                       lb_oe_reg;
    logic [7:0]                 lo_byte_reg;
    logic                       lo_oe_reg;
    logic [5:0]                 hi_byte_reg;
    logic                       hi_oe_reg;

    dss_hs_if hs ();

    // =====================================================================
    // decoding helpers
    function automatic logic dss_last(input dss_pkg::dss_cnt_t cnt,
                                      input dss_pkg::dss_cnt_t len);
        dss_last = (cnt == len - 13'h0001);
    endfunction : dss_last

    wire in_az      = (ph_reg == dss_pkg::PH_AZ);
    wire in_wait    = (ph_reg == dss_pkg::PH_WAIT);
    wire in_start   = (ph_reg == dss_pkg::PH_START);
    wire in_int     = (ph_reg == dss_pkg::PH_INT);
    wire in_de      = (ph_reg == dss_pkg::PH_DE);
    wire az_end     = in_az && dss_last(cnt_reg, `DSS_AZ_LEN);
    wire start_end  = in_start && dss_last(cnt_reg, `DSS_START_DLY);
    wire int_end    = in_int && dss_last(cnt_reg, `DSS_INT_LEN);
    wire de_end     = in_de && dss_last(cnt_reg, `DSS_DE_LEN);
    // first zero crossing of this reference phase
    wire zero_hit   = in_de && !crossed_reg && cmp_zero;
    // full scale reached without a crossing
    wire over_hit   = de_end && !crossed_reg && !cmp_zero;
    wire latch_go   = zero_hit || over_hit;
    // a transfer in progress freezes the latches; the result is dropped
    wire latch_en   = latch_go && !hs.busy;
    wire cut_short  = in_de && crossed_reg && !run_hold;
    wire mode_rise  = mode_in && !mode_prev_reg;
    wire ctl_drive  = mode_in || hs.busy;
    wire rd_lo      = !ctl_drive && !chip_sel_n_in && !low_byte_select_n_in;
    wire rd_hi      = !ctl_drive && !chip_sel_n_in && !high_byte_select_n_in;
    wire [7:0] lo_byte_val = result_reg[`DSS_LO_MSB:0];
    wire [5:0] hi_byte_val = {over_reg, res_sign_reg,
                              result_reg[`DSS_RES_W-1:`DSS_HI_LSB]};

    // =====================================================================
    // phase sequencer
    always_comb begin
        ph_next  = ph_reg;
        cnt_next = cnt_reg + 13'h0001;
        unique case (ph_reg)
            dss_pkg::PH_AZ: begin
                if (az_end) begin
                    cnt_next = '0;
                    ph_next  = run_hold ? dss_pkg::PH_INT : dss_pkg::PH_WAIT;
                end
            end
            dss_pkg::PH_WAIT: begin
                cnt_next = '0;
                if (run_hold) begin
                    ph_next = dss_pkg::PH_START;
                end
            end
            dss_pkg::PH_START: begin
                if (start_end) begin
                    cnt_next = '0;
                    ph_next  = dss_pkg::PH_INT;
                end
            end
            dss_pkg::PH_INT: begin
                if (int_end) begin
                    cnt_next = '0;
                    ph_next  = dss_pkg::PH_DE;
                end
            end
            dss_pkg::PH_DE: begin
                if (cut_short || de_end) begin
                    cnt_next = '0;
                    ph_next  = dss_pkg::PH_AZ;
                end
            end
            default: begin
                cnt_next = '0;
                ph_next  = dss_pkg::PH_AZ;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg  <= dss_pkg::PH_AZ;
            cnt_reg <= '0;
            zph_reg <= 1'b1;
        end else begin
            ph_reg  <= ph_next;
            cnt_reg <= cnt_next;
            zph_reg <= |ph_next[2:0];
        end
    end

    // =====================================================================
    // polarity, crossing and result latches
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sign_reg    <= 1'b0;
            crossed_reg <= 1'b0;
        end else begin
            if (int_end) begin
                sign_reg <= cmp_pos;
            end
            if (in_int) begin
                crossed_reg <= 1'b0;
            end else if (zero_hit) begin
                crossed_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_reg   <= `DSS_RESULT_RST;
            res_sign_reg <= 1'b0;
            over_reg     <= 1'b0;
        end else if (latch_en) begin
            // count to crossing; full scale wraps with flag
            result_reg   <= cnt_reg[`DSS_RES_W-1:0] + {{(`DSS_RES_W-1){1'b0}}, over_hit};
            res_sign_reg <= sign_reg;
            over_reg     <= over_hit;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_done_reg <= 1'b0;
        end else begin
            latch_done_reg <= latch_go;
        end
    end

    // status lives on the falling edge so its drop lands half a clock after latching
    always_ff @(negedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 1'b0;
        end else if (latch_done_reg) begin
            status_reg <= 1'b0;
        end else if (in_int) begin
            status_reg <= 1'b1;
        end
    end

    // =====================================================================
    // handshake request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_prev_reg <= 1'b0;
            hs_req_reg    <= 1'b0;
        end else begin
            mode_prev_reg <= mode_in;
            // pulse or level request, set wins over the take
            if (!hs.busy && (mode_rise || (mode_in && latch_en))) begin
                hs_req_reg <= 1'b1;
            end else if (hs.start) begin
                hs_req_reg <= 1'b0;
            end
        end
    end

    // taken one clock after a latch, so the bytes are already stable
    assign hs.start = hs_req_reg && !hs.busy && !latch_en;
    assign hs.send  = send;

    dss_hs_seq u_hs_seq (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .hs      (hs.seq)
    );

    // =====================================================================
    // pin drivers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_sel_n_out_reg <= 1'b1;
            chip_sel_n_oe_reg  <= 1'b0;
            hb_out_reg         <= 1'b1;
            hb_oe_reg          <= 1'b0;
            lb_out_reg         <= 1'b1;
            lb_oe_reg          <= 1'b0;
        end else begin
            chip_sel_n_oe_reg  <= ctl_drive;
            hb_oe_reg          <= ctl_drive;
            lb_oe_reg          <= ctl_drive;
            chip_sel_n_out_reg <= hs.load_n;
            hb_out_reg         <= hs.hi_n;
            lb_out_reg         <= hs.lo_n;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_byte_reg <= 8'h00;
            hi_byte_reg <= 6'h00;
            lo_oe_reg   <= 1'b0;
            hi_oe_reg   <= 1'b0;
        end else begin
            lo_byte_reg <= lo_byte_val;
            hi_byte_reg <= hi_byte_val;
            lo_oe_reg   <= rd_lo || hs.drv_lo;
            hi_oe_reg   <= rd_hi || hs.drv_hi;
        end
    end

    assign chip_sel_n_out         = chip_sel_n_out_reg;
    assign chip_sel_n_oe          = chip_sel_n_oe_reg;
    assign high_byte_select_n_out = hb_out_reg;
    assign high_byte_select_n_oe  = hb_oe_reg;
    assign low_byte_select_n_out  = lb_out_reg;
    assign low_byte_select_n_oe   = lb_oe_reg;
    assign lo_byte_out            = lo_byte_reg;
    assign lo_byte_oe             = lo_oe_reg;
    assign hi_byte_out            = hi_byte_reg;
    assign hi_byte_oe             = hi_oe_reg;
    assign status                 = status_reg;
    assign zero_phase             = zph_reg;
    assign int_phase              = ph_reg[3];
    assign reference_phase        = ph_reg[4];
    assign sign_bit               = sign_reg;

    // =====================================================================
    // checks
    logic [12:0] int_run_reg;
    logic [13:0] cyc_len_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_run_reg <= '0;
            cyc_len_reg <= '0;
        end else begin
            int_run_reg <= in_int ? int_run_reg + 13'h0001 : 13'h0000;
            cyc_len_reg <= (ph_next == dss_pkg::PH_INT && !in_int) ? 14'h0001 :
                           cut_short ? 14'h0000 : cyc_len_reg + 14'h0001;
        end
    end

    sequence s_gate_seen;
        in_wait && run_hold;
    endsequence

    sequence s_enter_int;
        ##8 in_int && status_reg;
    endsequence

    property p_start_delay;
        @(posedge ref_clk) disable iff (!rst_n)
        s_gate_seen |-> s_enter_int;
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("integrate start not 7 clocks");

    property p_int_len;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(int_phase) |-> int_run_reg == `DSS_INT_LEN;
    endproperty
    a_int_len: assert property (p_int_len) else $error("integrate length wrong");

    property p_cycle_len;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(int_phase) && $past(in_az) && $past(cyc_len_reg) > 14'h0800 |->
            $past(cyc_len_reg) == `DSS_CYCLE_LEN;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");

    property p_status_fall;
        @(posedge ref_clk) disable iff (!rst_n)
        latch_go |=> !status_reg;
    endproperty
    a_status_fall: assert property (p_status_fall) else $error("status stayed high");

    property p_stable;
        @(posedge ref_clk) disable iff (!rst_n)
        !status_reg && !$past(status_reg) |-> $stable(result_reg) && $stable(over_reg);
    endproperty
    a_stable: assert property (p_stable) else $error("latch changed while status low");

    property p_cut;
        @(posedge ref_clk) disable iff (!rst_n)
        in_de && crossed_reg && !run_hold |=> in_az && cnt_reg == 13'h0000;
    endproperty
    a_cut: assert property (p_cut) else $error("reference phase not cut");

    property p_halt;
        @(posedge ref_clk) disable iff (!rst_n)
        az_end && !run_hold |=> in_wait;
    endproperty
    a_halt: assert property (p_halt) else $error("auto-zero did not halt");

    property p_over;
        @(posedge ref_clk) disable iff (!rst_n)
        over_hit && !hs.busy |=> over_reg && result_reg == 12'h000;
    endproperty
    a_over: assert property (p_over) else $error("over-range not latched");

    property p_pulse_entry;
        @(posedge ref_clk) disable iff (!rst_n)
        mode_rise && !hs.busy |-> ##[1:3] hs.busy;
    endproperty
    a_pulse_entry: assert property (p_pulse_entry) else $error("no handshake entry");

    property p_direct_read;
        @(posedge ref_clk) disable iff (!rst_n)
        rd_lo && !rd_hi && !hs.busy |=> lo_byte_oe && !hi_byte_oe && lo_byte_out == $past(lo_byte_val);
    endproperty
    a_direct_read: assert property (p_direct_read) else $error("direct read wrong");
endmodule : dss_ctrl

// ==== sim/dss_host_model.sv ====
// host, receiver and analog front-end model facing the converter control block
`timescale 1ns/1ps
module dss_host_model (
    input  wire logic        ref_clk,
    input  wire logic        reference_phase,
    input  wire logic [12:0] target,
    input  wire logic        slow,
    input  wire logic        rd_cs_n,
    input  wire logic        rd_hb_n,
    input  wire logic        rd_lb_n,
    input  wire logic        cs_out,
    input  wire logic        cs_oe,
    input  wire logic        hb_out,
    input  wire logic        hb_oe,
    input  wire logic        lb_out,
    input  wire logic        lb_oe,
    input  wire logic [7:0]  lo_byte_out,
    input  wire logic        lo_byte_oe,
    input  wire logic [5:0]  hi_byte_out,
    input  wire logic        hi_byte_oe,
    output logic             cmp_zero,
    output logic             send,
    output logic             cs_pin,
    output logic             hb_pin,
    output logic             lb_pin,
    output logic [15:0]      rx_word,
    output int               rx_n
);
    logic [12:0] ref_cnt_reg = 13'h0000;
    logic [15:0] word_reg    = 16'h0000;
    int          cnt_reg     = 0;
    int          hold_reg    = 0;
    logic [7:0]  rx_byte;

    // ==========================================================
    // select pins and comparator
    // released selects float high through pull-ups
    assign cs_pin = cs_oe ? cs_out : rd_cs_n;
    assign hb_pin = hb_oe ? hb_out : rd_hb_n;
    assign lb_pin = lb_oe ? lb_out : rd_lb_n;
    assign cmp_zero = reference_phase && (ref_cnt_reg >= target);
    always @(posedge ref_clk) begin
        ref_cnt_reg <= reference_phase ? ref_cnt_reg + 13'h0001 : 13'h0000;
    end

    // ==========================================================
    // byte receiver
    // a byte whose drivers are off reads as a marker, not as stale data
    assign rx_byte = (!hb_pin && hi_byte_oe) ? {2'b00, hi_byte_out} :
                     (!lb_pin && lo_byte_oe) ? lo_byte_out : 8'hEE;
    assign send    = (hold_reg == 0) && !(slow && cs_oe && !cs_out);
    assign rx_word = word_reg;
    assign rx_n    = cnt_reg;
    // bytes taken on load strobe; slow receiver stalls
    always @(posedge ref_clk) begin
        if (cs_oe && !cs_out) begin
            word_reg <= {word_reg[7:0], rx_byte};
            cnt_reg  <= cnt_reg + 1;
            hold_reg <= slow ? 20 : 0;
        end else if (hold_reg > 0) begin
            hold_reg <= hold_reg - 1;
        end
    end
endmodule : dss_host_model

// ==== sim/dss_ctrl_bench.sv ====
// self-checking testbench of the converter control block
`timescale 1ns/1ps
module dss_ctrl_bench;
    logic        ref_clk = 1'b0, rst_n = 1'b0, run_hold = 1'b1, mode_in = 1'b0;
    logic        cmp_pos = 1'b1, slow = 1'b0, rd_cs_n = 1'b1, rd_hb_n = 1'b1, rd_lb_n = 1'b1;
    logic [12:0] target = 13'h0A5C;
    logic        send, cmp_zero, cs_pin, hb_pin, lb_pin, cs_out, cs_oe, hb_out, hb_oe;
    logic        lb_out, lb_oe, lo_byte_oe, hi_byte_oe, status, zero_phase, int_phase;
    logic        reference_phase, sign_bit;
    logic [7:0]  lo_byte_out;
    logic [5:0]  hi_byte_out;
    logic [15:0] rx_word;
    int          rx_n, rx_want = 0, cyc = 0, fails = 0, n_checks = 0;

    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    dss_ctrl dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .run_hold(run_hold), .mode_in(mode_in),
        .send(send), .cmp_zero(cmp_zero), .cmp_pos(cmp_pos), .chip_sel_n_in(cs_pin),
        .chip_sel_n_out(cs_out), .chip_sel_n_oe(cs_oe), .high_byte_select_n_in(hb_pin),
        .high_byte_select_n_out(hb_out), .high_byte_select_n_oe(hb_oe),
        .low_byte_select_n_in(lb_pin), .low_byte_select_n_out(lb_out),
        .low_byte_select_n_oe(lb_oe), .lo_byte_out(lo_byte_out), .lo_byte_oe(lo_byte_oe),
        .hi_byte_out(hi_byte_out), .hi_byte_oe(hi_byte_oe), .status(status),
        .zero_phase(zero_phase), .int_phase(int_phase), .reference_phase(reference_phase),
        .sign_bit(sign_bit));
    dss_host_model host_u (
        .ref_clk(ref_clk), .reference_phase(reference_phase), .target(target), .slow(slow),
        .rd_cs_n(rd_cs_n), .rd_hb_n(rd_hb_n), .rd_lb_n(rd_lb_n), .cs_out(cs_out),
        .cs_oe(cs_oe), .hb_out(hb_out), .hb_oe(hb_oe), .lb_out(lb_out), .lb_oe(lb_oe),
        .lo_byte_out(lo_byte_out), .lo_byte_oe(lo_byte_oe), .hi_byte_out(hi_byte_out),
        .hi_byte_oe(hi_byte_oe), .cmp_zero(cmp_zero), .send(send), .cs_pin(cs_pin),
        .hb_pin(hb_pin), .lb_pin(lb_pin), .rx_word(rx_word), .rx_n(rx_n));

    // ==========================================================
    // compare and access tasks
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val
    task automatic check_num(input int got, input int exp, input string what);
        n_checks++;
        if (got != exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : check_num
    function automatic logic pick(input int k);
        case (k)
            0: return status;
            1: return int_phase;
            2: return zero_phase;
            default: return rx_n >= rx_want;
        endcase
    endfunction : pick

    // polled on the falling edge, after rising-edge updates
    task automatic wait_for(input int k, input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge ref_clk);
            if (pick(k) === v) break;
        end
        if (i == lim) check_num(i, -1, "wait limit");
    endtask : wait_for

    task automatic read_byte(input logic cs, input logic hi, output logic [7:0] d,
                             output logic oe);
        @(posedge ref_clk);
        rd_cs_n <= !cs;
        rd_hb_n <= !hi;
        rd_lb_n <= hi;
        repeat (2) @(posedge ref_clk);
        #1;
        oe = hi ? hi_byte_oe : lo_byte_oe;
        d  = hi ? {2'b00, hi_byte_out} : lo_byte_out;
        @(posedge ref_clk);
        {rd_cs_n, rd_hb_n, rd_lb_n} <= 3'b111;
    endtask : read_byte
    task automatic check_result(input logic ovr, input logic sgn, input logic [11:0] r);
        logic [7:0] d;
        logic       oe;
        read_byte(1'b1, 1'b0, d, oe);
        check_val({7'h00, oe, d}, {8'h01, r[7:0]}, "low byte");
        read_byte(1'b1, 1'b1, d, oe);
        check_val({7'h00, oe, d}, {8'h01, 2'b00, ovr, sgn, r[11:8]}, "high byte");
        read_byte(1'b0, 1'b1, d, oe);
        check_val({15'h0000, oe}, 16'h0000, "read without chip select");
        check_val({15'h0000, sign_bit}, {15'h0000, sgn}, "sign");
    endtask : check_result

    task automatic end_test(input string name);
        $display("test %s done, checks %0d, mismatches %0d", name, n_checks, fails);
    endtask : end_test

    task automatic final_report;
        $display("total checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // ==========================================================
    // status edges come half a clock after the state change
    always @(status) begin
        if (rst_n === 1'b1) begin
            check_val({15'h0000, ref_clk}, 16'h0000, "status edge on falling clock");
            if (status === 1'b1) check_val({15'h0000, int_phase}, 16'h0001, "rise");
        end
    end

    initial begin
        #1500000;
        fails++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        final_report;
    end

    // ==========================================================
    // test sequence
    initial begin
        int a;
        repeat (3) @(posedge ref_clk);
        #1;
        check_val({8'h00, cs_oe, hb_oe, lb_oe, lo_byte_oe, hi_byte_oe, status, zero_phase,
                   cs_out}, 16'h0003, "reset state");
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_for(1, 1'b1, 3000);
        a = cyc;
        wait_for(1, 1'b0, 3000);
        check_num(cyc - a, 2048, "integrate length");
        check_val({15'h0000, reference_phase}, 16'h0001, "phase order");
        wait_for(0, 1'b0, 5000);
        check_result(1'b0, 1'b1, 12'hA5C);
        wait_for(1, 1'b1, 6000);
        check_num(cyc - a, 8192, "cycle length");
        end_test("free run");
        @(posedge ref_clk);
        target  <= 13'h1000;
        cmp_pos <= 1'b0;
        wait_for(0, 1'b0, 8000);
        check_result(1'b1, 1'b0, 12'h000);
        end_test("over range");
        @(posedge ref_clk);
        target  <= 13'h0064;
        cmp_pos <= 1'b1;
        wait_for(0, 1'b1, 4000);
        wait_for(0, 1'b0, 3000);
        check_result(1'b0, 1'b1, 12'h064);
        @(posedge ref_clk);
        run_hold <= 1'b0;
        wait_for(2, 1'b1, 4);
        a = cyc;
        check_val({15'h0000, reference_phase}, 16'h0000, "reference phase cut");
        repeat (10) @(posedge ref_clk);
        run_hold <= 1'b1;
        wait_for(1, 1'b1, 3000);
        check_num(cyc - a, 2048, "minimum auto-zero");
        wait_for(0, 1'b0, 3000);
        @(posedge ref_clk);
        run_hold <= 1'b0;
        repeat (3000) @(posedge ref_clk);
        #1;
        check_val({14'h0000, zero_phase, int_phase}, 16'h0002, "held in auto-zero");
        @(posedge ref_clk);
        run_hold <= 1'b1;
        repeat (8) @(negedge ref_clk);
        #1;
        check_val({14'h0000, int_phase, status}, 16'h0000, "start delay");
        @(negedge ref_clk);
        #1;
        check_val({14'h0000, int_phase, status}, 16'h0003, "integrate start");
        end_test("run hold");
        @(posedge ref_clk);
        mode_in <= 1'b1;
        target  <= 13'h0123;
        rx_want = rx_n + 2;
        wait_for(3, 1'b1, 100);
        check_val(rx_word, 16'h1064, "on-demand bytes");
        rx_want = rx_n + 2;
        wait_for(0, 1'b0, 8000);
        wait_for(3, 1'b1, 100);
        check_val(rx_word, 16'h1123, "bytes after conversion");
        check_val({15'h0000, cs_oe}, 16'h0001, "outputs active");
        end_test("handshake held");
        @(posedge ref_clk);
        mode_in <= 1'b0;
        slow    <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        check_val({13'h0000, cs_oe, hb_oe, lb_oe}, 16'h0000, "direct mode pins");
        rx_want = rx_n + 2;
        @(posedge ref_clk);
        mode_in <= 1'b1;
        @(posedge ref_clk);
        mode_in <= 1'b0;
        wait_for(3, 1'b1, 200);
        check_val(rx_word, 16'h1123, "pulsed bytes with stalls");
        repeat (24) @(posedge ref_clk);
        #1;
        check_val({13'h0000, cs_oe, hb_oe, lb_oe}, 16'h0000, "back to direct");
        check_result(1'b0, 1'b1, 12'h123);
        end_test("handshake pulse");
        final_report;
    end
endmodule : dss_ctrl_bench
